// ---- core/rm_core_ctrl.sv ----
// Real-mode control: address path, lock sequencing, halt and shutdown.
// Assumes a decoder and execution unit on core_clk_in; pins synchronised.
//
// Behaviour
// - Reset enters real address mode.
// - Default operand size is 16 bits; 32-bit needs an override prefix.
// - Effective addresses are valid only within the 64K segment.
// - Bus lock is never honoured on repeated string instructions.
// - Lock accepted only on listed read-modify-write memory-destination forms.
// - Lock on any other form raises invalid-opcode exception 6.
// - Locked read, modify and write happen with the bus held locked.
// - Lock is accepted at any privilege level.
// - Real mode reaches 1 Mbyte; address lines 2 to 19 vary.
// - After reset upper lines high on code cycles until far jump/call.
// - No paging; physical equals linear address.
// - Physical address is segment shifted left four plus offset.
// - Segments are 64K and allow read, write and execute untyped.
// - Access past offset FFFFH raises general-protection exception 13.
// - Segments may overlap and overlap is not checked.
// - Interrupt vector table spans 00000H to 003FFH, four bytes each.
// - Exceptions 10, 11 and 14 never occur in real mode.
// - Halt stops fetching and leaves the local bus idle.
// - Halt exits on NMI, enabled maskable request, or reset.
// - Vector beyond table limit on interrupt, 8 or 13 gives shutdown; code checks interrupts, NMI, 6 and 13 (8 is never raised).
`timescale 1ns/100ps
`default_nettype none
module rm_core_ctrl
  import rm_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire decode_t dec_in,
  input wire logic dec_valid_in,
  input wire mem_req_t mem_req_in,
  input wire logic [31:0] next_offset_in,
  input wire logic if_flag_in,
  input wire logic nmi_pin_in,
  input wire logic maskable_irq_request_in,
  input wire logic [7:0] irq_vector_in,
  input wire logic [9:0] idt_limit_in,
  input wire logic bus_done_in,
  output logic [29:0] word_address_lines_low_out,
  output logic [11:0] upper_address_lines_out,
  output logic bus_req_out,
  output logic bus_lock_out,
  output logic bus_write_out,
  output logic fetch_en_out,
  output logic real_mode_out,
  output logic [1:0] opsize_out,
  output exc_t exc_out,
  output logic [31:0] saved_offset_out,
  output logic shutdown_out,
  output logic halted_out
);

  logic nmi_s1_r;
  logic nmi_s2_r;
  logic nmi_s3_r;
  logic irq_s1_r;
  logic irq_s2_r;
  logic upper_force_r;
  cpu_state_t state_r;
  cpu_state_t state_nxt;
  logic [31:0] phys_addr;
  logic limit_fault;
  logic lock_ok;
  logic lock_illegal;
  logic nmi_edge;
  logic irq_take;
  logic wake;
  logic [7:0] vec_sel;
  logic vec_req;
  logic vec_bad;
  logic [31:0] halt_ret_r;
  logic [17:0] lock_addr_r;

  // Byte address of the last byte of a vector in the table
  function automatic logic [31:0] vec_end(input logic [7:0] v);
    vec_end = IVT_BASE + {22'h0, v, 2'h0} + 32'(VEC_BYTES - 1);
  endfunction

  // True in either half of a locked read-modify-write
  function automatic logic in_lock(input cpu_state_t s);
    in_lock = (s == ST_LOCK_READ || s == ST_LOCK_WRITE);
  endfunction

  rm_addr_gen u_addr
  (
    .req_in(mem_req_in),
    .upper_force_in(upper_force_r),
    .phys_addr_out(phys_addr),
    .limit_fault_out(limit_fault)
  );

  rm_lock_check u_lock
  (
    .dec_in(dec_in),
    .lock_ok_out(lock_ok),
    .lock_illegal_out(lock_illegal)
  );

  // Pin inputs cross two flops before any logic sees them
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      nmi_s1_r <= 1'b0;
      nmi_s2_r <= 1'b0;
      nmi_s3_r <= 1'b0;
      irq_s1_r <= 1'b0;
      irq_s2_r <= 1'b0;
    end
    else
    begin
      nmi_s1_r <= nmi_pin_in;
      nmi_s2_r <= nmi_s1_r;
      nmi_s3_r <= nmi_s2_r;
      irq_s1_r <= maskable_irq_request_in;
      irq_s2_r <= irq_s1_r;
    end
  end

  assign nmi_edge = nmi_s2_r && !nmi_s3_r;
  assign irq_take = irq_s2_r && if_flag_in;
  assign wake = nmi_edge || irq_take;

  // Exceptions 6 and 13, NMI and interrupts all go through the vector check
  always_comb
  begin
    vec_req = 1'b0;
    vec_sel = EXC_NONE;
    if (state_r == ST_RUN && mem_req_in.valid && limit_fault)
    begin
      vec_req = 1'b1;
      vec_sel = EXC_GP;
    end
    else if (state_r == ST_RUN && dec_valid_in && lock_illegal)
    begin
      vec_req = 1'b1;
      vec_sel = EXC_INVALID_OP;
    end
    else if ((state_r == ST_RUN || state_r == ST_HALT) && nmi_edge)
    begin
      vec_req = 1'b1;
      vec_sel = 8'h02;
    end
    else if ((state_r == ST_RUN || state_r == ST_HALT) && irq_take)
    begin
      vec_req = 1'b1;
      vec_sel = irq_vector_in;
    end
    vec_bad = vec_req && (vec_end(vec_sel) > {22'h0, idt_limit_in});
  end

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN:
      begin
        if (vec_bad)
          state_nxt = ST_SHUTDOWN;
        else if (dec_valid_in && dec_in.halt_instruction)
          state_nxt = ST_HALT;
        else if (dec_valid_in && lock_ok && mem_req_in.valid && !limit_fault)
          state_nxt = ST_LOCK_READ;
      end
      ST_HALT:
      begin
        if (vec_bad)
          state_nxt = ST_SHUTDOWN;
        else if (wake)
          state_nxt = ST_RUN;
      end
      ST_LOCK_READ:
        if (bus_done_in)
          state_nxt = ST_LOCK_WRITE;
      ST_LOCK_WRITE:
        if (bus_done_in)
          state_nxt = ST_RUN;
      ST_SHUTDOWN:
        state_nxt = ST_SHUTDOWN;
      default:
        state_nxt = ST_RUN;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      state_r <= ST_RUN;
    else
      state_r <= state_nxt;
  end

  // Far transfer ends the forced-high upper address window
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      upper_force_r <= UPPER_FORCE_RST;
    else if (state_r == ST_RUN && dec_valid_in && dec_in.far_transfer)
      upper_force_r <= 1'b0;
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      halt_ret_r <= 32'h0;
    else if (state_r == ST_RUN && dec_valid_in && dec_in.halt_instruction)
      halt_ret_r <= next_offset_in;
  end

  // Operand address kept for the write half; the request has gone by then
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      lock_addr_r <= 18'h0;
    else if (state_r == ST_RUN && state_nxt == ST_LOCK_READ)
      lock_addr_r <= phys_addr[19:2];
  end

  // Bus outputs; lock stays up across both halves of the locked cycle
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      word_address_lines_low_out <= 30'h0;
      upper_address_lines_out <= 12'h0;
      bus_req_out <= 1'b0;
      bus_lock_out <= 1'b0;
      bus_write_out <= 1'b0;
    end
    else
    begin
      bus_lock_out <= in_lock(state_nxt);
      bus_write_out <= (state_nxt == ST_LOCK_WRITE);
      // Both locked halves run on the bus, whatever the request input does
      bus_req_out <= in_lock(state_nxt) ||
        (mem_req_in.valid && !limit_fault && state_nxt == ST_RUN);
      // Only lines 2 to 19 carry the address (line 20 wraps above 1M)
      if (in_lock(state_r))
        word_address_lines_low_out <= {12'h0, lock_addr_r};
      else
        word_address_lines_low_out <= {12'h0, phys_addr[19:2]};
      upper_address_lines_out <= upper_force_r && mem_req_in.is_code ?
        UPPER_ONES : 12'h0;
    end
  end

  // Only vectors 2, 6, 13 and interrupts: 10, 11, 14 never raised
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      exc_out <= '0;
    else
    begin
      exc_out.valid <= vec_req && !vec_bad;
      exc_out.vector <= vec_sel;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      saved_offset_out <= 32'h0;
    else if (state_r == ST_HALT && wake)
      saved_offset_out <= halt_ret_r;
  end

  // Run, halt and shutdown flags all follow the next state
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      shutdown_out <= 1'b0;
      halted_out <= 1'b0;
      fetch_en_out <= 1'b0;
    end
    else
    begin
      shutdown_out <= (state_nxt == ST_SHUTDOWN);
      halted_out <= (state_nxt == ST_HALT);
      fetch_en_out <= (state_nxt == ST_RUN);
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      real_mode_out <= MODE_REAL_RST;
      opsize_out <= OPSIZE_16;
    end
    else
    begin
      // No protected mode here, so the device never leaves real mode
      real_mode_out <= 1'b1;
      // Segment access type is never checked
      opsize_out <= (dec_valid_in && dec_in.opsize_prefix) ?
        OPSIZE_32 : OPSIZE_16;
    end
  end

endmodule
`default_nettype wire

// ---- core/rm_pkg.sv ----
// Package for the real-mode address, lock check and halt control block.
// Assumes a single 25 MHz core clock domain; no software registers.
package rm_pkg;

  localparam logic [31:0] SEG_LIMIT = 32'h0000FFFF;
  localparam int SEG_SHIFT = 4;
  localparam logic [31:0] PHYS_MAX = 32'h0010FFEF;
  localparam logic [31:0] IVT_BASE = 32'h00000000;
  localparam logic [31:0] IVT_LAST = 32'h000003FF;
  localparam int VEC_BYTES = 4;
  localparam logic [7:0] EXC_INVALID_OP = 8'h06;
  localparam logic [7:0] EXC_DOUBLE = 8'h08;
  localparam logic [7:0] EXC_GP = 8'h0D;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [1:0] OPSIZE_16 = 2'h1;
  localparam logic [1:0] OPSIZE_32 = 2'h2;
  localparam logic [11:0] UPPER_ONES = 12'hFFF;
  localparam logic [9:0] IDT_LIMIT_RST = 10'h3FF;
  localparam logic MODE_REAL_RST = 1'b1;
  localparam logic UPPER_FORCE_RST = 1'b1;

  // Instruction classes presented by the decoder
  typedef enum logic [3:0] {
    OP_BIT_TSC,
    OP_XCHG,
    OP_ALU,
    OP_UNARY,
    OP_STRING_REP,
    OP_OTHER
  } op_class_t;

  typedef struct packed {
    logic lock_prefix;
    logic opsize_prefix;
    logic addrsize_prefix;
    op_class_t op_class;
    logic mem_is_dest;
    logic mem_is_src;
    logic far_transfer;
    logic halt_instruction;
  } decode_t;

  typedef struct packed {
    logic valid;
    logic is_code;
    logic [15:0] segment;
    logic [31:0] offset;
    logic [2:0] size_bytes;
  } mem_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] vector;
  } exc_t;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_HALT,
    ST_SHUTDOWN,
    ST_LOCK_READ,
    ST_LOCK_WRITE
  } cpu_state_t;

endpackage

// ---- core/rm_addr_gen.sv ----
// Real-mode address formation and 64K segment limit check.
// Assumes requests from the execution unit on the core clock.
`timescale 1ns/100ps
`default_nettype none
module rm_addr_gen
  import rm_pkg::*;
(
  input wire mem_req_t req_in,
  input wire logic upper_force_in,
  output logic [31:0] phys_addr_out,
  output logic limit_fault_out
);

  logic [31:0] last_byte;
  logic [31:0] lin;

  always_comb
  begin
    // Last byte of the access must not pass the segment end
    last_byte = req_in.offset + {29'h0, req_in.size_bytes} - 32'h1;
    limit_fault_out = req_in.valid && (req_in.offset > SEG_LIMIT ||
      last_byte > SEG_LIMIT || last_byte < req_in.offset);
    // Linear equals physical: no page translation here
    lin = ({16'h0, req_in.segment} << SEG_SHIFT) +
      {16'h0, req_in.offset[15:0]};
    phys_addr_out = lin;
    if (req_in.is_code && upper_force_in)
    begin
      phys_addr_out[31:20] = UPPER_ONES;
    end
  end

endmodule
`default_nettype wire

// ---- core/rm_lock_check.sv ----
// Bus-lock prefix legality check for one decoded instruction.
// Assumes the decoder presents a stable decode_t for the cycle.
`timescale 1ns/100ps
`default_nettype none
module rm_lock_check
  import rm_pkg::*;
(
  input wire decode_t dec_in,
  output logic lock_ok_out,
  output logic lock_illegal_out
);

  logic form_ok;

  always_comb
  begin
    // Privilege level plays no part in this decision
    unique case (dec_in.op_class)
      OP_BIT_TSC: form_ok = dec_in.mem_is_dest;
      OP_XCHG: form_ok = dec_in.mem_is_dest || dec_in.mem_is_src;
      OP_ALU: form_ok = dec_in.mem_is_dest;
      OP_UNARY: form_ok = dec_in.mem_is_dest;
      OP_STRING_REP: form_ok = 1'b0;
      default: form_ok = 1'b0;
    endcase
    lock_ok_out = dec_in.lock_prefix && form_ok;
    lock_illegal_out = dec_in.lock_prefix && !form_ok;
  end

endmodule
`default_nettype wire

// ---- testbench/rm_core_ctrl_checker.sv ----
// Port-level assertions for rm_core_ctrl.
// Assumes one clock domain; bound to every rm_core_ctrl instance.
`timescale 1ns/100ps
`default_nettype none
module rm_checker
  import rm_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire decode_t dec_in,
  input wire logic dec_valid_in,
  input wire mem_req_t mem_req_in,
  input wire logic [9:0] idt_limit_in,
  input wire logic nmi_pin_in,
  input wire logic bus_done_in,
  input wire logic [29:0] word_address_lines_low_out,
  input wire logic bus_req_out,
  input wire logic bus_lock_out,
  input wire logic fetch_en_out,
  input wire logic real_mode_out,
  input wire logic [1:0] opsize_out,
  input wire exc_t exc_out,
  input wire logic shutdown_out,
  input wire logic halted_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  logic acc, fits, bad;
  logic [31:0] phys;
  logic [17:0] wl;
  assign acc = fetch_en_out && mem_req_in.valid && !dec_valid_in;
  assign fits = mem_req_in.offset + mem_req_in.size_bytes <= 33'h10000;
  assign phys = {12'h0, mem_req_in.segment, 4'h0} + mem_req_in.offset;
  assign wl = phys[19:2];
  // Exchange takes memory on either side, so it is legal without a dest
  assign bad = dec_in.op_class > OP_UNARY ||
    (!dec_in.mem_is_dest && dec_in.op_class != OP_XCHG);
  AST_REAL: assert property (real_mode_out)
    else $error("left real mode");
  AST_OPSIZE: assert property (fetch_en_out && dec_valid_in &&
    dec_in.opsize_prefix |=> opsize_out == OPSIZE_32) else $error("opsize");
  AST_ADDR: assert property (acc && fits |=> bus_req_out &&
    word_address_lines_low_out == {12'h0, $past(wl)}) else $error("addr");
  AST_GP: assert property (acc && !fits |=> !bus_req_out &&
    (($past(idt_limit_in) >= {EXC_GP, 2'h3}) ?
    (exc_out.valid && exc_out.vector == EXC_GP) : shutdown_out))
    else $error("no gp");
  AST_BADLOCK: assert property (fetch_en_out && dec_valid_in &&
    dec_in.lock_prefix && bad && fits |=> exc_out.valid &&
    exc_out.vector == EXC_INVALID_OP) else $error("bad lock taken");
  AST_LOCKHOLD: assert property (bus_lock_out && !bus_done_in |=>
    bus_lock_out) else $error("lock dropped");
  AST_HALT: assert property (halted_out |-> !fetch_en_out &&
    !bus_req_out && !bus_lock_out) else $error("bus used in halt");
  AST_SHUT: assert property (shutdown_out |=> shutdown_out &&
    !fetch_en_out && !bus_req_out) else $error("left shutdown");
  AST_NMI: assert property (halted_out && !shutdown_out &&
    $rose(nmi_pin_in) |-> ##[1:5] !halted_out) else $error("still halted");
  cover property (bus_lock_out && bus_done_in);
  cover property ($rose(shutdown_out));
  cover property (exc_out.valid && exc_out.vector == EXC_GP);
endmodule
bind rm_core_ctrl rm_checker u_rm_checker (.core_clk_in, .rst_n_in,
  .dec_in, .dec_valid_in, .mem_req_in, .idt_limit_in, .nmi_pin_in,
  .bus_done_in, .word_address_lines_low_out, .bus_req_out, .bus_lock_out,
  .fetch_en_out, .real_mode_out, .opsize_out, .exc_out, .shutdown_out,
  .halted_out);
`default_nettype wire

// ---- testbench/mem_io_model.sv ----
// Local bus partner: ends each locked phase with a done pulse.
// Assumes the lock output rises at the start of the locked read.
`timescale 1ns/100ps
`default_nettype none
module mem_io_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic bus_lock_in,
  input wire logic slow_in,
  output logic bus_done_out
);
  logic [2:0] wait_r;
  // Slow mode stretches a phase so the held lock is really exercised
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wait_r <= 3'h0;
      bus_done_out <= 1'b0;
    end
    else
    begin
      bus_done_out <= bus_lock_in && !bus_done_out && wait_r == 3'h0;
      if (!bus_lock_in || bus_done_out)
        wait_r <= slow_in ? 3'h4 : 3'h0;
      else if (wait_r != 3'h0)
        wait_r <= wait_r - 3'h1;
    end
  end
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Self-checking bench for rm_core_ctrl with a locked-bus partner.
// Assumes rm_pkg, the model and the checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import rm_pkg::*;
;
  logic core_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  decode_t dec_in = '0;
  logic dec_valid_in = 1'b0;
  mem_req_t mem_req_in = '0;
  logic [31:0] next_offset_in = 32'h0;
  logic if_flag_in = 1'b0;
  logic nmi_pin_in = 1'b0;
  logic maskable_irq_request_in = 1'b0;
  logic [7:0] irq_vector_in = 8'h20;
  logic [9:0] idt_limit_in = 10'h3FF;
  logic slow = 1'b0;
  logic bus_done_in, bus_req_out, bus_lock_out, bus_write_out;
  logic fetch_en_out, real_mode_out, shutdown_out, halted_out;
  logic [29:0] word_address_lines_low_out;
  logic [11:0] upper_address_lines_out;
  logic [1:0] opsize_out;
  exc_t exc_out;
  logic [31:0] saved_offset_out;
  int error_cnt = 0;
  int check_count = 0;
  rm_core_ctrl u_rm_core_ctrl (.core_clk_in, .rst_n_in, .dec_in,
    .dec_valid_in, .mem_req_in, .next_offset_in, .if_flag_in, .nmi_pin_in,
    .maskable_irq_request_in, .irq_vector_in, .idt_limit_in, .bus_done_in,
    .word_address_lines_low_out, .upper_address_lines_out, .bus_req_out,
    .bus_lock_out, .bus_write_out, .fetch_en_out, .real_mode_out,
    .opsize_out, .exc_out, .saved_offset_out, .shutdown_out, .halted_out);
  mem_io_model u_mem_io_model (.clk_in(core_clk_in), .rst_n_in,
    .bus_lock_in(bus_lock_out), .slow_in(slow), .bus_done_out(bus_done_in));
  initial
  begin
    forever #20 core_clk_in = ~core_clk_in;
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic go();
    @(posedge core_clk_in);
  endtask
  task automatic wait_lvl(ref logic s, input logic v);
    for (int n = 0; n < 40 && s !== v; n++)
    begin
      go();
      #1;
    end
    chk("wait", 32'(s), 32'(v));
    if (s !== v)
      wrap_up();
  endtask
  task automatic issue(decode_t d, mem_req_t m, logic v);
    go();
    dec_in <= d;
    dec_valid_in <= v;
    mem_req_in <= m;
    go();
    dec_valid_in <= 1'b0;
    mem_req_in.valid <= 1'b0;
    #1;
  endtask
  function automatic logic [31:0] phys_of(logic [15:0] sg, logic [31:0] of);
    return {12'h0, sg, 4'h0} + of;
  endfunction
  initial
  begin : main
    logic [31:0] of, p;
    logic [2:0] sz;
    logic ok;
    void'($urandom(13));
    go();
    #1;
    chk("opsize", 32'(opsize_out), 32'(OPSIZE_16));
    repeat (2) go();
    rst_n_in <= 1'b1;
    go();
    #1;
    chk("fetch", 32'(fetch_en_out), 32'h1);
    issue('0, '{1'b1, 1'b1, 16'h1234, 32'h10, 3'h1}, 1'b0);
    chk("upper", 32'(upper_address_lines_out), 32'hFFF);
    issue(decode_t'(11'h202), '0, 1'b1);
    issue('0, '{1'b1, 1'b1, 16'h1234, 32'h10, 3'h1}, 1'b0);
    chk("upper", 32'(upper_address_lines_out), 32'h0);
    $display("reset test done");
    // Random offsets below the limit, then bytes, words and dwords at the edge
    for (int i = 0; i < 25; i++)
    begin
      sz = 3'(1 << (i % 3));
      of = (i < 20) ? $urandom % (32'h10001 - sz) : 32'hFFE9 + i;
      p = $urandom;
      issue('0, '{1'b1, 1'b0, p[15:0], of, sz}, 1'b0);
      ok = of + sz <= 32'h10000;
      p = phys_of(p[15:0], of);
      chk("req", 32'(bus_req_out), 32'(ok));
      chk("gp", 32'(exc_out.valid), 32'(!ok));
      if (ok)
        chk("addr", 32'(word_address_lines_low_out), {14'h0, p[19:2]});
    end
    $display("address test done");
    for (int i = 0; i < 7; i++)
    begin
      ok = i < 4;
      slow <= i[0];
      issue(decode_t'({1'b1, 2'h0, 4'(i == 6 ? 2 : i), i != 6, i == 6,
        2'h0}), '{1'b1, 1'b0, 16'h0100, 32'h20, 3'h2}, 1'b1);
      chk("lockexc", 32'(exc_out), ok ? 32'h0 : 32'h106);
      chk("lock", 32'(bus_lock_out), 32'(ok));
      if (ok)
      begin
        wait_lvl(bus_write_out, 1'b1);
        wait_lvl(bus_lock_out, 1'b0);
      end
    end
    $display("lock test done");
    p = $urandom;
    go();
    next_offset_in <= p;
    maskable_irq_request_in <= 1'b1;
    issue(decode_t'(11'h001), '0, 1'b1);
    repeat (8) go();
    #1;
    chk("halt", 32'(halted_out), 32'h1);
    go();
    nmi_pin_in <= 1'b1;
    wait_lvl(halted_out, 1'b0);
    chk("nmi", 32'(exc_out), 32'h102);
    chk("ret", saved_offset_out, p);
    go();
    nmi_pin_in <= 1'b0;
    maskable_irq_request_in <= 1'b0;
    issue(decode_t'(11'h001), '0, 1'b1);
    go();
    if_flag_in <= 1'b1;
    maskable_irq_request_in <= 1'b1;
    wait_lvl(halted_out, 1'b0);
    chk("irq", 32'(exc_out), 32'h120);
    $display("halt test done");
    for (int i = 0; i < 2; i++)
    begin
      go();
      idt_limit_in <= i ? 10'h01F : 10'h07F;
      irq_vector_in <= 8'h40;
      maskable_irq_request_in <= i == 0;
      if (i)
        issue('0, '{1'b1, 1'b0, 16'h0, 32'hFFFF, 3'h2}, 1'b0);
      wait_lvl(shutdown_out, 1'b1);
      repeat (4) go();
      #1;
      chk("stuck", 32'({shutdown_out, fetch_en_out}), 32'h2);
      go();
      rst_n_in <= 1'b0;
      maskable_irq_request_in <= 1'b0;
      idt_limit_in <= 10'h3FF;
      go();
      rst_n_in <= 1'b1;
      go();
      #1;
      chk("wake", 32'({shutdown_out, fetch_en_out}), 32'h1);
    end
    $display("shutdown test done");
    wrap_up();
  end
endmodule
`default_nettype wire
